// ### hdl/monitor_core_state_control.sv
// file: operating-state sequencer of the battery monitor core
`default_nettype none
module monitor_core_state_control #(
	parameter int REF_SETTLE_CYC = mcsc_pkg::REF_SETTLE_CYC, // settle count
	parameter int SLEEP_CYC = mcsc_pkg::SLEEP_CYC, // inactivity count
	parameter int UPD_CYC = mcsc_pkg::UPD_CYC, // continuous period
	parameter int CONV_CYC = mcsc_pkg::CONV_CYC // single cycle length
) (
	input wire logic core_clk, // core clock
	input wire logic nrst, // power-on reset, active low
	input wire mcsc_pkg::mcsc_cmd_type cmd, // decoded host command
	input wire logic watchdogTimeout, // watchdog ran out, pulse
	input wire logic wakeUp, // wake-up signal, pulse
	input wire logic dischargeTimeoutNonZero, // discharge_timeout not 0
	input wire logic dischargeExpired, // discharge timeout ran out, pulse
	input wire logic interfaceSelectPin, // high isolated, low spi
	input wire logic chipSelect_n, // four-wire chip select, active low
	input wire logic serialDataOut, // serial bit to send
	input wire logic retWrite, // retention byte write strobe
	input wire logic [2:0] retAddr, // retention byte index
	input wire logic [7:0] retData, // retention byte value
	input wire logic [mcsc_pkg::NUM_GPIO-1:0] gpioDirOut, // 1 = output
	input wire logic [mcsc_pkg::NUM_GPIO-1:0] gpioOutVal, // output value
	input wire logic [mcsc_pkg::NUM_GPIO-1:0] gpioIn, // pin levels
	input wire logic gpioMasterEn, // pins three-five as master port
	output mcsc_pkg::mcsc_state_type coreState, // current state
	output mcsc_pkg::mcsc_pwr_type pwr, // power controls
	output logic [mcsc_pkg::NUM_ADC-1:0] resultUpdate, // result stored
	output logic [mcsc_pkg::NUM_ADC-1:0] filterFeed, // result to iir
	output logic [mcsc_pkg::NUM_ADC-1:0] convRestart, // conversion start
	output logic isoMode, // isolated interface selected
	output logic spiSelected, // four-wire frame in progress
	output logic sdoOut, // serial output driven level, always 0
	output logic sdoOe_n, // serial output enable, low pulls low
	output logic regsClear, // reset of ordinary registers, pulse
	output logic [8*mcsc_pkg::RET_BYTES-1:0] retention, // kept bytes
	output logic [mcsc_pkg::NUM_GPIO-1:0] gpioOut, // pin output value
	output logic [mcsc_pkg::NUM_GPIO-1:0] gpioOe_n, // pin enable, low
	output logic [mcsc_pkg::NUM_GPIO-1:0] gpioInReg, // sampled pins
	output logic masterPortOn // master port owns pins three-five
);
	default clocking mcsc_cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ----------------------------------------------------------------
	// state record
	// ----------------------------------------------------------------
	typedef struct packed {
		mcsc_pkg::mcsc_state_type state; // core state
		logic keepOn; // reference_keep_on value
		logic continuous_conversion; // continuous conversion active
		logic [mcsc_pkg::NUM_ADC-1:0] active; // converters in use
		logic [mcsc_pkg::CNT_W-1:0] convCnt; // conversion cycle timer
		mcsc_pkg::mcsc_pwr_type pwr; // registered power controls
		logic [mcsc_pkg::NUM_ADC-1:0] upd; // result update pulse
		logic [mcsc_pkg::NUM_ADC-1:0] filt; // filter feed pulse
		logic [mcsc_pkg::NUM_ADC-1:0] rst; // conversion restart pulse
		logic iso; // interface mode
		logic spiSel; // chip select asserted
		logic sdoOe_n; // serial output enable
		logic clr; // register clear pulse
		logic [8*mcsc_pkg::RET_BYTES-1:0] ret; // retention bytes
		logic [mcsc_pkg::NUM_GPIO-1:0] gOut; // gpio outputs
		logic [mcsc_pkg::NUM_GPIO-1:0] gOe_n; // gpio enables
		logic [mcsc_pkg::NUM_GPIO-1:0] gIn; // gpio inputs
		logic mst; // master port active
		logic armed; // inactivity timer armed once after reset
	} mcsc_core_type;
	mcsc_core_type st_ff; // registered state
	mcsc_core_type nxt_st; // next state

	// ----------------------------------------------------------------
	// timers
	// ----------------------------------------------------------------
	logic settleDone; // reference settled, pulse
	logic sleepDone; // inactivity elapsed, pulse
	logic settleStart; // start reference settle
	logic idleState; // state in which inactivity counts, settle too
	logic idleNext; // state being entered also counts inactivity
	logic anyConv; // a convert command this cycle
	logic keepOnWrite; // config write sets keep-on this cycle
	logic keepOnNext; // keep-on value after this cycle

	assign anyConv = cmd.valid && (cmd.convert != '0);
	assign keepOnWrite = cmd.valid && cmd.writeConfigGroupA;
	assign keepOnNext = keepOnWrite ? cmd.referenceKeepOn : st_ff.keepOn;
	assign idleState = st_ff.state inside {mcsc_pkg::ST_STANDBY,
		mcsc_pkg::ST_REFUP, mcsc_pkg::ST_SETTLE};
	assign idleNext = nxt_st.state inside {mcsc_pkg::ST_STANDBY,
		mcsc_pkg::ST_REFUP, mcsc_pkg::ST_SETTLE};
	// settle begins from standby on convert or on keep-on set
	assign settleStart = (st_ff.state == mcsc_pkg::ST_STANDBY) &&
		(anyConv || (keepOnWrite && cmd.referenceKeepOn));

	// settle timer starts only when settle begins from standby; converts while waiting do not restart it
	mcsc_timer u_settle (
		.core_clk(core_clk),
		.nrst(nrst),
		.restart(settleStart),
		.stop(st_ff.state != mcsc_pkg::ST_SETTLE && !settleStart),
		.load(REF_SETTLE_CYC[mcsc_pkg::CNT_W-1:0]),
		.expired(settleDone)
	);

	// inactivity timer: every valid command rearms it
	mcsc_timer u_sleep (
		.core_clk(core_clk),
		.nrst(nrst),
		.restart(cmd.valid || !st_ff.armed ||
			(idleNext && !idleState)),
		.stop(!idleNext),
		.load(SLEEP_CYC[mcsc_pkg::CNT_W-1:0]),
		.expired(sleepDone)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// one process builds every field; state decides power and timers
	always_comb begin
		nxt_st = st_ff;
		nxt_st.upd = '0;
		nxt_st.filt = '0;
		nxt_st.rst = '0;
		nxt_st.clr = 1'b0;
		nxt_st.keepOn = keepOnNext;
		nxt_st.armed = 1'b1;
		unique case (st_ff.state)
			mcsc_pkg::ST_STANDBY: begin
				if (settleStart) begin
					nxt_st.state = mcsc_pkg::ST_SETTLE;
				end else if (sleepDone && !cmd.valid) begin
					nxt_st.state = dischargeTimeoutNonZero ?
						mcsc_pkg::ST_EXTBAL : mcsc_pkg::ST_SLEEP;
				end
			end
			mcsc_pkg::ST_SETTLE: begin
				if (settleDone) begin
					// a pending convert measures, else hold reference
					nxt_st.state = (st_ff.active != '0) ?
						mcsc_pkg::ST_MEASURE : mcsc_pkg::ST_REFUP;
					nxt_st.rst = st_ff.active;
					nxt_st.convCnt = '0;
				end
			end
			mcsc_pkg::ST_REFUP: begin
				if (anyConv) begin
					nxt_st.state = mcsc_pkg::ST_MEASURE;
					nxt_st.rst = cmd.convert;
					nxt_st.convCnt = '0;
				end else if (keepOnWrite && !cmd.referenceKeepOn) begin
					nxt_st.state = mcsc_pkg::ST_STANDBY;
				end else if (sleepDone && !cmd.valid) begin
					nxt_st.state = dischargeTimeoutNonZero ?
						mcsc_pkg::ST_EXTBAL : mcsc_pkg::ST_SLEEP;
				end
			end
			mcsc_pkg::ST_MEASURE: begin
				nxt_st.convCnt = st_ff.convCnt + 32'h0000_0001;
				if (anyConv) begin
					// resynchronise: affected converters start over
					nxt_st.rst = cmd.convert;
					nxt_st.convCnt = '0;
				end else if (st_ff.continuous_conversion) begin
					if (st_ff.convCnt ==
						UPD_CYC[mcsc_pkg::CNT_W-1:0] - 32'h0000_0001) begin
						nxt_st.upd = st_ff.active;
						nxt_st.filt = st_ff.active;
						nxt_st.convCnt = '0;
					end
				end else if (st_ff.convCnt ==
					CONV_CYC[mcsc_pkg::CNT_W-1:0] - 32'h0000_0001) begin
					nxt_st.upd = st_ff.active;
					nxt_st.active = '0;
					nxt_st.state = keepOnNext ?
						mcsc_pkg::ST_REFUP : mcsc_pkg::ST_STANDBY;
				end
			end
			mcsc_pkg::ST_EXTBAL: begin
				if (cmd.valid) begin
					nxt_st.state = mcsc_pkg::ST_STANDBY;
				end else if (dischargeExpired) begin
					nxt_st.state = mcsc_pkg::ST_SLEEP;
				end
			end
			mcsc_pkg::ST_SLEEP: begin
				if (wakeUp) begin
					nxt_st.state = mcsc_pkg::ST_STANDBY;
				end
			end
			default: begin
				nxt_st.state = mcsc_pkg::ST_STANDBY;
			end
		endcase
		// any convert picks converters and mode, except in sleep or extended balancing
		if (anyConv && st_ff.state != mcsc_pkg::ST_SLEEP &&
			st_ff.state != mcsc_pkg::ST_EXTBAL) begin
			nxt_st.active = cmd.convert;
			nxt_st.continuous_conversion = cmd.continuousConversion;
		end
		// watchdog overrides everything but an already sleeping core
		if (watchdogTimeout && st_ff.state != mcsc_pkg::ST_SLEEP) begin
			nxt_st.state = mcsc_pkg::ST_SLEEP;
		end
		// entering sleep clears ordinary registers, retention stays
		if (nxt_st.state == mcsc_pkg::ST_SLEEP &&
			st_ff.state != mcsc_pkg::ST_SLEEP) begin
			nxt_st.clr = 1'b1;
			nxt_st.keepOn = 1'b0;
			nxt_st.continuous_conversion = 1'b0;
			nxt_st.active = '0;
			nxt_st.gOe_n = '1;
			nxt_st.gOut = '0;
		end else if (retWrite &&
			retAddr < 3'(mcsc_pkg::RET_BYTES)) begin
			nxt_st.ret[retAddr*8 +: 8] = retData;
		end
		// power follows the state being entered
		nxt_st.pwr = '0;
		nxt_st.pwr.timersRun = 1'b1;
		nxt_st.pwr.pwmAllowed = 1'b1;
		nxt_st.pwr.driveOn = 1'b1;
		unique case (nxt_st.state)
			mcsc_pkg::ST_SLEEP: begin
				nxt_st.pwr.isoIdle = 1'b1;
				nxt_st.pwr.driveOn = 1'b0;
				nxt_st.pwr.pwmAllowed = 1'b0;
				nxt_st.pwr.timersRun = 1'b0;
			end
			mcsc_pkg::ST_SETTLE, mcsc_pkg::ST_REFUP: begin
				nxt_st.pwr.reference_keep_on = 1'b1;
			end
			mcsc_pkg::ST_MEASURE: begin
				nxt_st.pwr.reference_keep_on = 1'b1;
				nxt_st.pwr.adcOn = nxt_st.active;
			end
			default: begin
				nxt_st.pwr.reference_keep_on = 1'b0;
			end
		endcase
		// interface mode and open-drain serial output
		nxt_st.iso = interfaceSelectPin;
		nxt_st.spiSel = !interfaceSelectPin && !chipSelect_n;
		nxt_st.sdoOe_n = !(nxt_st.spiSel && !serialDataOut);
		// general purpose pins
		nxt_st.gIn = gpioIn;
		nxt_st.mst = gpioMasterEn;
		if (nxt_st.state != mcsc_pkg::ST_SLEEP) begin
			nxt_st.gOut = gpioOutVal;
			nxt_st.gOe_n = ~gpioDirOut;
		end
	end

	// ----------------------------------------------------------------
	// register; reset lands in standby with defaults
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			st_ff <= '0;
			st_ff.state <= mcsc_pkg::ST_STANDBY;
			st_ff.sdoOe_n <= 1'b1;
			st_ff.gOe_n <= ~mcsc_pkg::GPIO_DIR_RST;
			st_ff.pwr.driveOn <= 1'b1;
			st_ff.pwr.pwmAllowed <= 1'b1;
			st_ff.pwr.timersRun <= 1'b1;
			st_ff.ret <= {mcsc_pkg::RET_BYTES{mcsc_pkg::RET_RST}};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all but sdoOut, gpioOut and gpioOe_n straight from the state record
	// ----------------------------------------------------------------
	assign coreState = st_ff.state;
	assign pwr = st_ff.pwr;
	assign resultUpdate = st_ff.upd;
	assign filterFeed = st_ff.filt;
	assign convRestart = st_ff.rst;
	assign isoMode = st_ff.iso;
	assign spiSelected = st_ff.spiSel;
	assign sdoOut = 1'b0; // open drain never drives high
	assign sdoOe_n = st_ff.sdoOe_n;
	assign regsClear = st_ff.clr;
	assign retention = st_ff.ret;
	assign gpioInReg = st_ff.gIn;
	assign masterPortOn = st_ff.mst;

	// master port owns pins three to five; one loop over the pins
	genvar gi;
	generate
		for (gi = 0; gi < mcsc_pkg::NUM_GPIO; gi++) begin : g_pin
			if (gi >= mcsc_pkg::GPIO_MST_LO && gi <= mcsc_pkg::GPIO_MST_HI)
			begin : g_mst
				assign gpioOut[gi] = st_ff.gOut[gi] && !st_ff.mst;
				assign gpioOe_n[gi] = st_ff.gOe_n[gi] || st_ff.mst;
			end else begin : g_plain
				assign gpioOut[gi] = st_ff.gOut[gi];
				assign gpioOe_n[gi] = st_ff.gOe_n[gi];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_wd;
		watchdogTimeout && st_ff.state != mcsc_pkg::ST_SLEEP;
	endsequence
	a_watchdog_sleep: assert property (
		s_wd |=> coreState == mcsc_pkg::ST_SLEEP && !pwr.driveOn)
		else $error("watchdog did not sleep");
	a_sleep_power_off: assert property (
		coreState == mcsc_pkg::ST_SLEEP |->
		!pwr.reference_keep_on && pwr.adcOn == '0 && pwr.isoIdle)
		else $error("sleep left power on");
	a_wake_standby: assert property (
		coreState == mcsc_pkg::ST_SLEEP && wakeUp && !watchdogTimeout |=>
		coreState == mcsc_pkg::ST_STANDBY)
		else $error("wake-up ignored");
	a_standby_ref_off: assert property (
		coreState == mcsc_pkg::ST_STANDBY |->
		!pwr.reference_keep_on && pwr.adcOn == '0 && pwr.timersRun)
		else $error("standby power wrong");
	a_refup_ref_on: assert property (
		coreState == mcsc_pkg::ST_REFUP |-> pwr.reference_keep_on && pwr.adcOn == '0)
		else $error("reference-up power wrong");
	a_settle_entry: assert property (
		settleStart && !watchdogTimeout |=> coreState == mcsc_pkg::ST_SETTLE)
		else $error("settle not entered");
	a_keepon_exit: assert property (
		coreState == mcsc_pkg::ST_REFUP && keepOnWrite && !anyConv &&
		!cmd.referenceKeepOn && !watchdogTimeout |=>
		coreState == mcsc_pkg::ST_STANDBY)
		else $error("keep-on clear ignored");
	a_restart_conv: assert property (
		coreState == mcsc_pkg::ST_MEASURE && anyConv |=>
		convRestart == $past(cmd.convert))
		else $error("convert did not restart");
	a_extbal_exit: assert property (
		coreState == mcsc_pkg::ST_EXTBAL && cmd.valid && !watchdogTimeout
		|=> coreState == mcsc_pkg::ST_STANDBY)
		else $error("extended balancing kept");
	a_sdo_open_drain: assert property (
		!sdoOe_n |-> spiSelected && !sdoOut)
		else $error("serial output misdriven");
endmodule : monitor_core_state_control
`default_nettype wire

// ### hdl/mcsc_pkg.sv
// package: states, command carriers and timing constants of the core state control
`default_nettype none
package mcsc_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 250; // core clock rate in MHz
	localparam int REF_SETTLE_US = 4000; // reference settle time, us
	localparam int REF_SETTLE_CYC = REF_SETTLE_US * CLK_MHZ;
	localparam int SLEEP_MS = 1800; // inactivity sleep time, ms
	localparam int SLEEP_CYC = SLEEP_MS * 1000 * CLK_MHZ;
	localparam int UPD_US = 1000; // continuous result period, 1 kHz
	localparam int UPD_CYC = UPD_US * CLK_MHZ;
	localparam int CONV_US = 1000; // one single conversion cycle, us
	localparam int CONV_CYC = CONV_US * CLK_MHZ;
	localparam int CNT_W = 32; // width of every timer
	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam int NUM_ADC = 4; // cell, redundant, aux, second aux
	localparam int NUM_GPIO = 10; // general purpose pins
	localparam int RET_BYTES = 6; // retention bytes kept in sleep
	localparam int GPIO_MST_LO = 2; // index of pin three
	localparam int GPIO_MST_HI = 4; // index of pin five
	localparam logic [7:0] RET_RST = 8'h00; // retention byte at power-on
	localparam logic [NUM_GPIO-1:0] GPIO_DIR_RST = 10'h000; // all inputs

	typedef enum logic [2:0] {
		ST_STANDBY = 3'b000,
		ST_SLEEP = 3'b001,
		ST_REFUP = 3'b010,
		ST_MEASURE = 3'b011,
		ST_EXTBAL = 3'b100,
		ST_SETTLE = 3'b101
	} mcsc_state_type;

	// one host command, already decoded by the serial front end
	typedef struct packed {
		logic valid; // any valid command, one-cycle pulse
		logic [NUM_ADC-1:0] convert; // which converter command, one-hot
		logic continuousConversion; // repeat conversions when set
		logic writeConfigGroupA; // config group a write
		logic referenceKeepOn; // written value of reference_keep_on
	} mcsc_cmd_type;

	// power controls toward the analog side
	typedef struct packed {
		logic reference_keep_on; // reference powered
		logic [NUM_ADC-1:0] adcOn; // converters powered
		logic isoIdle; // isolated ports held idle
		logic driveOn; // regulator control output, 0 means 0 v
		logic pwmAllowed; // pwm discharge may run
		logic timersRun; // watchdog and discharge timer running
	} mcsc_pwr_type;
endpackage : mcsc_pkg
`default_nettype wire

// ### hdl/mcsc_timer.sv
// file: a loadable down counter that pulses when it runs out
`default_nettype none
module mcsc_timer (
	input wire logic core_clk, // core clock
	input wire logic nrst, // synchronous reset, active low
	input wire logic restart, // reload and start counting
	input wire logic stop, // halt without firing
	input wire logic [mcsc_pkg::CNT_W-1:0] load, // cycles to count
	output logic expired // one-cycle pulse at run out
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic run; // counting
		logic [mcsc_pkg::CNT_W-1:0] cnt; // cycles left
		logic fire; // registered expiry pulse
	} mcsc_tmr_type;
	mcsc_tmr_type st_ff; // registered state
	mcsc_tmr_type nxt_st; // next state

	// restart wins over stop so a fresh command always rearms
	always_comb begin
		nxt_st = st_ff;
		nxt_st.fire = 1'b0;
		if (restart) begin
			nxt_st.run = 1'b1;
			nxt_st.cnt = load;
		end else if (stop) begin
			nxt_st.run = 1'b0;
		end else if (st_ff.run) begin
			if (st_ff.cnt <= 32'h0000_0001) begin
				nxt_st.run = 1'b0;
				nxt_st.fire = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
			end
		end
	end

	// register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign expired = st_ff.fire;
endmodule : mcsc_timer
`default_nettype wire

// ### test/mcsc_host_model.sv
// file: host side model that issues decoded commands and resolves sdo
`default_nettype none
module mcsc_host_model (
	input wire logic core_clk, // core clock
	input wire logic sdoOut, // level the device drives
	input wire logic sdoOe_n, // device enable, low pulls low
	output mcsc_pkg::mcsc_cmd_type cmd, // command toward the device
	output logic sdoWire // resolved serial line
);
	timeunit 1ns;
	timeprecision 1ps;
	// open drain with a pull-up: a released line reads high
	assign sdoWire = sdoOe_n ? 1'b1 : sdoOut;
	initial cmd = '0;
	// one-cycle command launched just after an edge; keep-on rides a
	// config group a write
	task automatic send(input logic [3:0] cv, input logic continuous_conversion,
		input logic wcfg, input logic keep);
		@(posedge core_clk);
		#1;
		cmd = {1'b1, cv, continuous_conversion, wcfg, keep};
		@(posedge core_clk);
		#1;
		cmd = '0;
	endtask : send
endmodule : mcsc_host_model
`default_nettype wire

// ### test/monitor_core_state_control_tb.sv
// file: self-checking bench of the core state sequencer
`default_nettype none
module monitor_core_state_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// short counts so the run stays brief
	// ----------------------------------------------------------------
	localparam int REF = 10;
	localparam int SLP = 120;
	localparam int UPD = 12;
	localparam int CNV = 8;
	logic core_clk, nrst, wdt, wake, dtnz, dexp, isp, cs_n, sdi;
	logic retWrite, gMst;
	logic [2:0] retAddr;
	logic [7:0] retData;
	logic [9:0] gDir, gVal, gIn, gOut, gOe_n, gInReg;
	logic [3:0] resUpd, feed, rst4, updSeen, feedSeen, rstSeen, cv;
	logic isoMode, spiSel, sdoOut, sdoOe_n, regsClear, clrSeen, mst;
	logic [47:0] ret, retExp;
	logic [31:0] r;
	integer seed, errorCnt, cmpCount, updCnt, i;
	mcsc_pkg::mcsc_cmd_type cmd;
	mcsc_pkg::mcsc_state_type st;
	mcsc_pkg::mcsc_pwr_type pwr;
	mcsc_host_model host (.core_clk(core_clk), .sdoOut(sdoOut),
		.sdoOe_n(sdoOe_n), .cmd(cmd), .sdoWire());
	monitor_core_state_control #(.REF_SETTLE_CYC(REF), .SLEEP_CYC(SLP),
		.UPD_CYC(UPD), .CONV_CYC(CNV)) dut (.core_clk(core_clk),
		.nrst(nrst), .cmd(cmd), .watchdogTimeout(wdt), .wakeUp(wake),
		.dischargeTimeoutNonZero(dtnz), .dischargeExpired(dexp),
		.interfaceSelectPin(isp), .chipSelect_n(cs_n),
		.serialDataOut(sdi), .retWrite(retWrite), .retAddr(retAddr),
		.retData(retData), .gpioDirOut(gDir), .gpioOutVal(gVal),
		.gpioIn(gIn), .gpioMasterEn(gMst), .coreState(st), .pwr(pwr),
		.resultUpdate(resUpd), .filterFeed(feed), .convRestart(rst4),
		.isoMode(isoMode), .spiSelected(spiSel), .sdoOut(sdoOut),
		.sdoOe_n(sdoOe_n), .regsClear(regsClear), .retention(ret),
		.gpioOut(gOut), .gpioOe_n(gOe_n), .gpioInReg(gInReg),
		.masterPortOn(mst));
	// 250 mhz core clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// pulse collector, sampled mid-cycle away from the launch edge
	always @(negedge core_clk) begin
		if (clrSeen) begin
			{updSeen, feedSeen, rstSeen} = '0;
			updCnt = 0;
		end else begin
			updSeen |= resUpd;
			feedSeen |= feed;
			rstSeen |= rst4;
			updCnt += int'(resUpd[0]);
		end
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic ok, input string m);
		cmpCount++;
		if (ok !== 1'b1) begin
			errorCnt++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	// waits a bounded number of cycles for a state; early arrival fails
	task automatic waitSt(input mcsc_pkg::mcsc_state_type s,
		input int lo, input int hi);
		int n;
		n = 0;
		while (st !== s && n <= hi) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(st === s && n >= lo && n <= hi, "state arrival time");
	endtask : waitSt
	// reference expected powered in these states
	function automatic logic refExp(input mcsc_pkg::mcsc_state_type s);
		return s == mcsc_pkg::ST_SETTLE || s == mcsc_pkg::ST_REFUP ||
			s == mcsc_pkg::ST_MEASURE;
	endfunction : refExp
	// pins three to five are handed to the master port when it is on
	function automatic logic [9:0] oeExp(input logic [9:0] d,
		input logic m);
		return ~d | (m ? 10'h01c : 10'h000);
	endfunction : oeExp
	// one conversion; from reference-up it skips the settle wait
	task automatic single(input logic [3:0] c, input logic keep);
		clrSeen = 1'b1;
		host.send(c, 1'b0, 1'b0, 1'b0);
		clrSeen = 1'b0;
		if (!keep) begin
			chk(refExp(st) === pwr.reference_keep_on, "settle power");
			waitSt(mcsc_pkg::ST_MEASURE, REF, REF + 2);
		end
		chk(pwr.adcOn === c && pwr.reference_keep_on === 1'b1, "measure");
		waitSt(keep ? mcsc_pkg::ST_REFUP : mcsc_pkg::ST_STANDBY,
			CNV - 1, CNV + 1);
		chk((updSeen | resUpd) === c && rstSeen === c, "result");
		chk(pwr.reference_keep_on === keep && pwr.adcOn === 4'h0, "back");
	endtask : single
	task automatic summarize;
		$display("compares %0d mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	// hang guard, well past the expected length of the run
	initial begin
		#40000;
		errorCnt++;
		summarize();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h0000_5fc6;
		{errorCnt, cmpCount} = '0;
		{nrst, wdt, wake, dtnz, dexp, isp, cs_n, sdi, gMst} = 9'h001;
		{retWrite, retAddr, retData, gDir, gVal, gIn} = '0;
		clrSeen = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 nrst = 1'b1;
		chk(st === mcsc_pkg::ST_STANDBY && pwr.reference_keep_on === 1'b0 &&
			pwr.adcOn === 4'h0 && pwr.driveOn === 1'b1, "reset");
		chk(pwr.pwmAllowed === 1'b1 && pwr.timersRun === 1'b1, "sby");
		retExp = '0;
		for (i = 0; i < 7; i++) begin // index six must be dropped
			r = $random(seed);
			retWrite = 1'b1;
			retAddr = 3'(i);
			retData = r[7:0];
			if (i < 6)
				retExp[8*i +: 8] = r[7:0];
			@(posedge core_clk);
			#1;
		end
		retWrite = 1'b0;
		@(posedge core_clk);
		#1 chk(ret === retExp, "retention write");
		for (i = 0; i < 4; i++)
			single(4'h1 << i, 1'b0);
		$display("test single done");
		dtnz = 1'b1;
		waitSt(mcsc_pkg::ST_EXTBAL, SLP - REF - CNV - 4, SLP + 2);
		host.send(4'h0, 1'b0, 1'b0, 1'b0);
		waitSt(mcsc_pkg::ST_STANDBY, 0, 1);
		waitSt(mcsc_pkg::ST_EXTBAL, SLP - 1, SLP + 2);
		@(posedge core_clk);
		#1 dexp = 1'b1;
		@(posedge core_clk);
		#1 dexp = 1'b0;
		waitSt(mcsc_pkg::ST_SLEEP, 0, 1);
		{wake, dtnz} = 2'b10;
		@(posedge core_clk);
		#1 wake = 1'b0;
		waitSt(mcsc_pkg::ST_STANDBY, 0, 1);
		$display("test balancing done");
		host.send(4'h0, 1'b0, 1'b1, 1'b1);
		waitSt(mcsc_pkg::ST_REFUP, REF, REF + 2);
		chk(pwr.reference_keep_on === 1'b1 && pwr.adcOn === 4'h0, "refup");
		r = $random(seed);
		single(4'h1 << r[1:0], 1'b1);
		host.send(4'h0, 1'b0, 1'b1, 1'b0);
		waitSt(mcsc_pkg::ST_STANDBY, 0, 1);
		host.send(4'h0, 1'b0, 1'b1, 1'b1);
		waitSt(mcsc_pkg::ST_REFUP, REF, REF + 2);
		clrSeen = 1'b1;
		waitSt(mcsc_pkg::ST_SLEEP, SLP - REF - 2, SLP - REF + 2);
		chk(pwr.reference_keep_on === 1'b0 && pwr.adcOn === 4'h0 &&
			pwr.isoIdle === 1'b1 && pwr.driveOn === 1'b0, "sleep");
		chk(ret === retExp, "retention kept");
		wake = 1'b1;
		@(posedge core_clk);
		#1 wake = 1'b0;
		$display("test reference done");
		host.send(4'h1, 1'b1, 1'b0, 1'b0);
		waitSt(mcsc_pkg::ST_MEASURE, REF, REF + 2);
		clrSeen = 1'b0;
		repeat (3 * UPD) @(posedge core_clk);
		#1 chk(updSeen === 4'h1 && feedSeen === 4'h1 && updCnt >= 2 &&
			updCnt <= 4, "continuous");
		host.send(4'h4, 1'b1, 1'b0, 1'b0);
		chk(rst4 === 4'h4 && st === mcsc_pkg::ST_MEASURE,
			"restart");
		wdt = 1'b1;
		@(posedge core_clk);
		#1 wdt = 1'b0;
		waitSt(mcsc_pkg::ST_SLEEP, 0, 1);
		chk(ret === retExp && regsClear === 1'b1, "wd clear");
		$display("test continuous done");
		wake = 1'b1;
		@(posedge core_clk);
		#1 wake = 1'b0;
		waitSt(mcsc_pkg::ST_STANDBY, 0, 1);
		for (i = 0; i < 10; i++) begin
			r = $random(seed);
			{isp, cs_n, sdi, gMst, gDir, gVal} = r[23:0];
			gIn = r[31:22];
			repeat (3) @(posedge core_clk);
			#1 chk(isoMode === isp && spiSel === (!isp && !cs_n), "mode");
			chk(host.sdoWire === !(!isp && !cs_n && !sdi) &&
				sdoOut === 1'b0, "sdo");
			chk(gOe_n === oeExp(gDir, gMst) && gInReg === gIn &&
				mst === gMst &&
				((gOut ^ gVal) & ~gOe_n) === 10'h000, "gpio");
		end
		$display("test pins done");
		summarize();
	end
endmodule : monitor_core_state_control_tb
`default_nettype wire
